// >>> include/rtv_pkg.sv
package rtv_pkg;

  // ==========================================================================
  // bus and register map
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam logic [3:0] OFS_WKDY_HOURS = 4'h0;
  localparam logic [3:0] OFS_MIN_SEC = 4'h4;
  localparam logic [3:0] OFS_CONTROL = 4'h8;
  localparam logic [3:0] OFS_ID = 4'hC;

  // arbitrary identification value
  localparam logic [15:0] ID_VALUE = 16'h5A31;

  // ==========================================================================
  // field layouts
  localparam int WKDY_LSB = 8;
  localparam int WKDY_W = 3;
  localparam int HRT_LSB = 4;
  localparam int HRT_W = 2;
  localparam int HRO_LSB = 0;
  localparam int HRO_W = 4;
  localparam int MINT_LSB = 12;
  localparam int MINT_W = 3;
  localparam int MINO_LSB = 8;
  localparam int MINO_W = 4;
  localparam int SECT_LSB = 4;
  localparam int SECT_W = 3;
  localparam int SECO_LSB = 0;
  localparam int SECO_W = 4;
  localparam int UNLOCK_BIT = 0;

  localparam logic [15:0] WKDY_HOURS_MASK = 16'h073F;
  localparam logic [15:0] MIN_SEC_MASK = 16'h7F7F;

  // legal maxima
  localparam logic [2:0] WKDY_MAX = 3'h6;
  localparam logic [1:0] HRT_MAX = 2'h2;
  localparam logic [3:0] ONES_MAX = 4'h9;
  localparam logic [2:0] TENS6_MAX = 3'h5;

  // ==========================================================================
  // types
  typedef struct packed {
    logic [2:0] weekday_digit;
    logic [1:0] hour_tens_digit;
    logic [3:0] hour_ones_digit;
  } rtv_wkhr_s;

  typedef struct packed {
    logic [2:0] minute_tens_digit;
    logic [3:0] minute_ones_digit;
    logic [2:0] second_tens_digit;
    logic [3:0] second_ones_digit;
  } rtv_minutes_seconds_value_s;

  typedef enum logic [2:0] {
    RTV_IDLE = 3'b001,
    RTV_ACK = 3'b010,
    RTV_DONE = 3'b100
  } rtv_bus_e;

endpackage

// >>> core/rtv_bcd_digit.sv
`timescale 1ns/100ps
// one time digit field; holds its value until a granted write
module rtv_bcd_digit #(
  parameter int W = 4
) (
  input wire logic ref_clk,
  input wire logic load,
  input wire logic [W-1:0] din,
  output logic [W-1:0] q
);
  // no reset: content is undefined until software writes it
  always_ff @(posedge ref_clk)
  begin
    if (load)
    begin
      q <= din;
    end
  end
endmodule

// >>> core/rtv_avalon_slave.sv
`timescale 1ns/100ps
// ============================================================================
// avalon-mm handshake: one wait cycle, then ack
module rtv_avalon_slave
  import rtv_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic read,
  input wire logic write,
  output logic waitrequest,
  output logic rd_strobe,
  output logic wr_strobe
);
  rtv_bus_e state_r;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= RTV_IDLE;
    end
    else
    begin
      case (state_r)
        RTV_IDLE: state_r <= (read || write) ? RTV_ACK : RTV_IDLE;
        RTV_ACK: state_r <= RTV_DONE;
        RTV_DONE: state_r <= RTV_IDLE;
        default: state_r <= RTV_IDLE;
      endcase
    end
  end

  // waitrequest low only in ACK, so an access raised in IDLE takes exactly two cycles (one raised in DONE takes three)
  always_comb
  begin
    waitrequest = !(state_r == RTV_ACK);
    rd_strobe = (state_r == RTV_ACK) && read;
    wr_strobe = (state_r == RTV_ACK) && write;
  end
endmodule

// >>> core/rtv_time_regs.sv
// Design decisions made here: the address map and the Avalon-MM register port.
`timescale 1ns/100ps
module rtv_time_regs
  import rtv_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [rtv_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [rtv_pkg::DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [rtv_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  output logic clock_write_unlock,
  output rtv_pkg::rtv_wkhr_s wkhr_value,
  output rtv_pkg::rtv_minutes_seconds_value_s minutes_seconds_value_value
);
  import rtv_pkg::*;

  // ==========================================================================
  // bus handshake
  logic rd_strobe;
  logic wr_strobe;
  logic wait_int;

  rtv_avalon_slave u_slave (
    .ref_clk(ref_clk),
    .rst(rst),
    .read(read),
    .write(write),
    .waitrequest(wait_int),
    .rd_strobe(rd_strobe),
    .wr_strobe(wr_strobe)
  );

  // the slave decodes waitrequest from its state; a local copy of that state
  // lets the bus outputs come straight from flip-flops with the same timing
  logic done_r;
  logic go_ack;
  logic wait_r;
  logic [DATA_W-1:0] readdata_r;

  // done_r marks the cycle after an ack, in which the slave takes no request
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= !wait_int;
    end
  end

  assign go_ack = wait_int && !done_r && (read || write);

  // waitrequest is high from reset and low exactly in the ack cycle
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wait_r <= 1'b1;
    end
    else
    begin
      wait_r <= !go_ack;
    end
  end
  assign waitrequest = wait_r;

  // ==========================================================================
  // decode
  logic [15:0] wdata16;
  logic lanes_lo;
  logic lanes_hi;
  logic wr_wkhr;
  logic wr_minutes_seconds_value;
  logic wr_ctrl;
  logic unlock_r;

  assign wdata16 = writedata[15:0];
  assign lanes_lo = byteenable[0];
  assign lanes_hi = byteenable[1];
  // a locked register simply drops the write; the bus still completes
  assign wr_wkhr = wr_strobe && (address == OFS_WKDY_HOURS) && unlock_r;
  assign wr_minutes_seconds_value = wr_strobe && (address == OFS_MIN_SEC);
  assign wr_ctrl = wr_strobe && (address == OFS_CONTROL) && lanes_lo;

  // ==========================================================================
  // unlock control bit
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      unlock_r <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      unlock_r <= wdata16[UNLOCK_BIT];
    end
  end
  assign clock_write_unlock = unlock_r;

  // ==========================================================================
  // digit storage, one instance per field
  rtv_wkhr_s wkhr_q;
  rtv_minutes_seconds_value_s ms_q;

  rtv_bcd_digit #(.W(WKDY_W)) u_wkdy (
    .ref_clk(ref_clk),
    .load(wr_wkhr && lanes_hi),
    .din(wdata16[WKDY_LSB +: WKDY_W]),
    .q(wkhr_q.weekday_digit)
  );
  rtv_bcd_digit #(.W(HRT_W)) u_hrt (
    .ref_clk(ref_clk),
    .load(wr_wkhr && lanes_lo),
    .din(wdata16[HRT_LSB +: HRT_W]),
    .q(wkhr_q.hour_tens_digit)
  );
  rtv_bcd_digit #(.W(HRO_W)) u_hro (
    .ref_clk(ref_clk),
    .load(wr_wkhr && lanes_lo),
    .din(wdata16[HRO_LSB +: HRO_W]),
    .q(wkhr_q.hour_ones_digit)
  );
  rtv_bcd_digit #(.W(MINT_W)) u_mint (
    .ref_clk(ref_clk),
    .load(wr_minutes_seconds_value && lanes_hi),
    .din(wdata16[MINT_LSB +: MINT_W]),
    .q(ms_q.minute_tens_digit)
  );
  rtv_bcd_digit #(.W(MINO_W)) u_mino (
    .ref_clk(ref_clk),
    .load(wr_minutes_seconds_value && lanes_hi),
    .din(wdata16[MINO_LSB +: MINO_W]),
    .q(ms_q.minute_ones_digit)
  );
  rtv_bcd_digit #(.W(SECT_W)) u_sect (
    .ref_clk(ref_clk),
    .load(wr_minutes_seconds_value && lanes_lo),
    .din(wdata16[SECT_LSB +: SECT_W]),
    .q(ms_q.second_tens_digit)
  );
  rtv_bcd_digit #(.W(SECO_W)) u_seco (
    .ref_clk(ref_clk),
    .load(wr_minutes_seconds_value && lanes_lo),
    .din(wdata16[SECO_LSB +: SECO_W]),
    .q(ms_q.second_ones_digit)
  );

  assign wkhr_value = wkhr_q;
  assign minutes_seconds_value_value = ms_q;

  // ==========================================================================
  // read mux; unimplemented bits are simply never placed
  logic [15:0] wkhr_word;
  logic [15:0] ms_word;
  logic [15:0] rd_word;

  always_comb
  begin
    wkhr_word = '0;
    wkhr_word[WKDY_LSB +: WKDY_W] = wkhr_q.weekday_digit;
    wkhr_word[HRT_LSB +: HRT_W] = wkhr_q.hour_tens_digit;
    wkhr_word[HRO_LSB +: HRO_W] = wkhr_q.hour_ones_digit;
    ms_word = '0;
    ms_word[MINT_LSB +: MINT_W] = ms_q.minute_tens_digit;
    ms_word[MINO_LSB +: MINO_W] = ms_q.minute_ones_digit;
    ms_word[SECT_LSB +: SECT_W] = ms_q.second_tens_digit;
    ms_word[SECO_LSB +: SECO_W] = ms_q.second_ones_digit;
    case (address)
      OFS_WKDY_HOURS: rd_word = wkhr_word & WKDY_HOURS_MASK;
      OFS_MIN_SEC: rd_word = ms_word & MIN_SEC_MASK;
      OFS_CONTROL: rd_word = {15'h0000, unlock_r};
      OFS_ID: rd_word = ID_VALUE;
      default: rd_word = 16'h0000;
    endcase
  end

  // read data is loaded on the edge that enters the ack cycle, so it stands
  // exactly while waitrequest is low; no write can land on that edge, since
  // writes only take effect at the end of the ack cycle itself
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      readdata_r <= '0;
    end
    else if (go_ack && read)
    begin
      readdata_r <= {16'h0000, rd_word};
    end
    else
    begin
      readdata_r <= '0;
    end
  end
  assign readdata = readdata_r;

  // ==========================================================================
  // assertions
  a_locked_no_write: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_strobe && address == OFS_WKDY_HOURS && !unlock_r)
      |=> $stable(wkhr_q))
    else $error("weekday-hours changed while locked");

  a_unlock_load: assert property (@(posedge ref_clk) disable iff (rst)
    wr_ctrl |=> (unlock_r == $past(wdata16[UNLOCK_BIT])))
    else $error("unlock bit not loaded");

  a_wkhr_upper_zero: assert property (@(posedge ref_clk) disable iff (rst)
    (rd_strobe && address == OFS_WKDY_HOURS)
      |-> ((readdata[REG_W-1:0] & ~WKDY_HOURS_MASK) == 16'h0000))
    else $error("weekday-hours unimplemented bits not zero");

  a_minutes_seconds_value_gaps_zero: assert property (@(posedge ref_clk) disable iff (rst)
    (rd_strobe && address == OFS_MIN_SEC)
      |-> ((readdata[REG_W-1:0] & ~MIN_SEC_MASK) == 16'h0000))
    else $error("minutes-seconds unimplemented bits not zero");

  a_upper_half_zero: assert property (@(posedge ref_clk) disable iff (rst)
    readdata[DATA_W-1:REG_W] == 16'h0000)
    else $error("upper read data half not zero");

  a_id_read: assert property (@(posedge ref_clk) disable iff (rst)
    (rd_strobe && address == OFS_ID) |-> (readdata == {16'h0000, ID_VALUE}))
    else $error("identification value wrong");

  a_weekday_store: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_wkhr && lanes_hi)
      |=> (wkhr_q.weekday_digit == $past(writedata[WKDY_LSB +: WKDY_W])))
    else $error("weekday digit not stored");

  a_hour_store: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_wkhr && lanes_lo)
      |=> (wkhr_q.hour_tens_digit == $past(writedata[HRT_LSB +: HRT_W])
      && wkhr_q.hour_ones_digit == $past(writedata[HRO_LSB +: HRO_W])))
    else $error("hour digits not stored");

  a_hour_lane_kept: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_wkhr && !lanes_lo)
      |=> ($stable(wkhr_q.hour_tens_digit) && $stable(wkhr_q.hour_ones_digit)))
    else $error("hour digits changed without their lane");

  a_minute_store: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_minutes_seconds_value && lanes_hi)
      |=> (ms_q.minute_tens_digit == $past(writedata[MINT_LSB +: MINT_W])
      && ms_q.minute_ones_digit == $past(writedata[MINO_LSB +: MINO_W])))
    else $error("minute digits not stored");

  a_minute_lane_kept: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_minutes_seconds_value && !lanes_hi)
      |=> ($stable(ms_q.minute_tens_digit) && $stable(ms_q.minute_ones_digit)))
    else $error("minute digits changed without their lane");

  a_second_store: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_minutes_seconds_value && lanes_lo)
      |=> (ms_q.second_tens_digit == $past(writedata[SECT_LSB +: SECT_W])
      && ms_q.second_ones_digit == $past(writedata[SECO_LSB +: SECO_W])))
    else $error("second digits not stored");

  a_second_lane_kept: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_minutes_seconds_value && !lanes_lo)
      |=> ($stable(ms_q.second_tens_digit) && $stable(ms_q.second_ones_digit)))
    else $error("second digits changed without their lane");

  a_unlock_gate: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_strobe && address == OFS_WKDY_HOURS && unlock_r && byteenable[1:0] == 2'h3)
      |=> (wkhr_q == {$past(writedata[WKDY_LSB +: WKDY_W]),
      $past(writedata[HRT_LSB +: HRT_W]), $past(writedata[HRO_LSB +: HRO_W])}))
    else $error("unlocked write lost");

  // a request raised right after an ack meets the done cycle and waits longer,
  // so a request only counts from a cycle that does not follow an ack
  sequence s_request;
    (read || write) && waitrequest && $past(waitrequest);
  endsequence

  sequence s_ack;
    (read || write) && !waitrequest;
  endsequence

  a_ack_one_wait: assert property (@(posedge ref_clk) disable iff (rst)
    s_request ##1 (read || write) |-> s_ack)
    else $error("ack not given in second cycle");

  a_ack_then_gap: assert property (@(posedge ref_clk) disable iff (rst)
    !waitrequest |=> waitrequest)
    else $error("ack not followed by a wait cycle");

  a_wait_mirror: assert property (@(posedge ref_clk) disable iff (rst)
    waitrequest == wait_int)
    else $error("registered waitrequest differs from the handshake state");

  a_rdata_idle_zero: assert property (@(posedge ref_clk) disable iff (rst)
    waitrequest |-> (readdata == '0))
    else $error("read data not zero outside the ack cycle");

endmodule

// >>> testbench/rtv_time_regs_tb.sv
`timescale 1ns/100ps
module rtv_time_regs_tb;
  import rtv_pkg::*;

  typedef struct {
    logic [3:0] a;
    logic [31:0] d;
    logic [3:0] be;
    logic [31:0] e;
  } rtv_row_s;

  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [ADDR_W-1:0] address = 4'h0;
  logic [DATA_W-1:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'h0;
  logic [DATA_W-1:0] readdata;
  logic [DATA_W-1:0] rd;
  logic waitrequest;
  logic clock_write_unlock;
  rtv_wkhr_s wkhr_value;
  rtv_minutes_seconds_value_s minutes_seconds_value_value;
  int miscompares = 0;
  int num_checks = 0;
  rtv_row_s rows [7];

  always #5 ref_clk = ~ref_clk;

  rtv_time_regs dut_u (
    .ref_clk(ref_clk),
    .rst(rst),
    .address(address),
    .read(read),
    .write(write),
    .writedata(writedata),
    .byteenable(byteenable),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .clock_write_unlock(clock_write_unlock),
    .wkhr_value(wkhr_value),
    .minutes_seconds_value_value(minutes_seconds_value_value)
  );

  task automatic test_done();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one avalon transfer; the request is held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int n;
    logic seen;
    logic [31:0] got;
    address <= a;
    writedata <= d;
    byteenable <= be;
    read <= !wr;
    write <= wr;
    n = 0;
    seen = 1'b1;
    got = 32'h0;
    // outputs change in the nba update of an edge, so reading them as the edge
    // wakes this task gives the values that the edge itself samples
    while (seen !== 1'b0 && n < 20)
    begin
      @(posedge ref_clk);
      n++;
      seen = waitrequest;
      got = readdata;
      if (seen === 1'b1)
        chk(got, 32'h0);
    end
    q = got;
    if (seen !== 1'b0)
    begin
      miscompares++;
      test_done();
    end
    else
    begin
      // exactly one wait cycle: the taking edge sees it high, the next one low
      chk(n, 2);
      read <= 1'b0;
      write <= 1'b0;
      // idle edge: the slave needs it before the next request, and no signal
      // is assigned twice in one time step
      @(posedge ref_clk);
    end
  endtask

  task automatic wr_rd(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
                       input logic [31:0] e);
    bus(1'b1, a, d, be, rd);
    bus(1'b0, a, 32'h0, 4'h0, rd);
    chk(rd, e);
  endtask

  initial
  begin
    rows[0] = '{OFS_WKDY_HOURS, 32'hFFFF_FFFF, 4'hF, 32'h0000_073F};
    rows[1] = '{OFS_WKDY_HOURS, 32'h0000_0623, 4'hF, 32'h0000_0623};
    rows[2] = '{OFS_WKDY_HOURS, 32'h0000_0409, 4'h2, 32'h0000_0423};
    rows[3] = '{OFS_MIN_SEC, 32'hFFFF_FFFF, 4'hF, 32'h0000_7F7F};
    rows[4] = '{OFS_MIN_SEC, 32'h0000_5959, 4'hF, 32'h0000_5959};
    rows[5] = '{OFS_MIN_SEC, 32'h0000_1234, 4'h1, 32'h0000_5934};
    rows[6] = '{OFS_MIN_SEC, 32'h0000_0000, 4'h0, 32'h0000_5934};
    // ==========================================================================
    // reset
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk);
    chk({31'h0, waitrequest}, 32'h1);
    chk(readdata, 32'h0);
    chk({31'h0, clock_write_unlock}, 32'h0);
    @(posedge ref_clk);
    rst <= 1'b0;
    bus(1'b0, OFS_CONTROL, 32'h0, 4'h0, rd);
    chk(rd, 32'h0);
    // ==========================================================================
    // table of writes and read-backs with the unlock bit set
    wr_rd(OFS_CONTROL, 32'h1, 4'hF, 32'h1);
    for (int i = 0; i < 7; i++)
      wr_rd(rows[i].a, rows[i].d, rows[i].be, rows[i].e);
    chk({23'h0, wkhr_value}, {23'h0, 3'h4, 2'h2, 4'h3});
    chk({18'h0, minutes_seconds_value_value}, {18'h0, 3'h5, 4'h9, 3'h3, 4'h4});
    // ==========================================================================
    // locked: weekday-hours ignores writes, minutes-seconds does not
    wr_rd(OFS_CONTROL, 32'h0, 4'hF, 32'h0);
    chk({31'h0, clock_write_unlock}, 32'h0);
    wr_rd(OFS_WKDY_HOURS, 32'h0000_0111, 4'hF, 32'h0000_0423);
    wr_rd(OFS_MIN_SEC, 32'h0000_0102, 4'hF, 32'h0000_0102);
    // unlocking again makes the same write land
    wr_rd(OFS_CONTROL, 32'h1, 4'h1, 32'h1);
    wr_rd(OFS_WKDY_HOURS, 32'h0000_0111, 4'hF, 32'h0000_0111);
    // ==========================================================================
    // id and unmapped places
    wr_rd(OFS_ID, 32'h0, 4'hF, {16'h0, ID_VALUE});
    wr_rd(4'h2, 32'hFFFF_FFFF, 4'hF, 32'h0);
    bus(1'b0, OFS_WKDY_HOURS, 32'h0, 4'h0, rd);
    chk(rd, 32'h0000_0111);
    // ==========================================================================
    // reset in mid-run clears the unlock bit and blocks the bus
    rst <= 1'b1;
    @(negedge ref_clk);
    chk({31'h0, waitrequest}, 32'h1);
    chk({31'h0, clock_write_unlock}, 32'h0);
    @(posedge ref_clk);
    rst <= 1'b0;
    wr_rd(OFS_WKDY_HOURS, 32'h0000_0222, 4'hF, 32'h0000_0111);
    test_done();
  end
endmodule
